// File: verilog/aop_defs.vh
// constants for the analog option port: register indices, fields, resets
// assumes: included by bare name from the port module only; the sync and pin cell modules do not include it
`ifndef AOP_DEFS_VH
`define AOP_DEFS_VH

// port width and bus widths
`define AOP_NPIN 4
`define AOP_DW 32
`define AOP_AW 32

// register indices; byte address is four times the index
`define AOP_IDX_DIR 6'h01
`define AOP_IDX_DATA 6'h04
`define AOP_IDX_OPT 6'h08
`define AOP_IDX_MODE 6'h09

// reset values
`define AOP_DIR_RST 4'h0
`define AOP_DATA_RST 4'h0
`define AOP_OPT_RST 10'h000

// option register fields
`define AOP_OPT_W 10
`define AOP_OPT_AMP 0
`define AOP_OPT_CMP1 1
`define AOP_OPT_CMP2 2
`define AOP_OPT_RZ1 3
`define AOP_OPT_RZ3 4
`define AOP_OPT_BIDIR 5
`define AOP_OPT_PD_LO 6
`define AOP_OPT_PD_HI 9

// pin bit positions with special read behaviour
`define AOP_BIT_CMP1 0
`define AOP_BIT_Z1 1
`define AOP_BIT_CMP2 2
`define AOP_BIT_Z3 3

// one-hot mode codes shown in the mode register
`define AOP_MODE_W 4
`define AOP_MODE_PURE 4'h1
`define AOP_MODE_AMP 4'h2
`define AOP_MODE_CMP 4'h4
`define AOP_MODE_CMPAMP 4'h8

// pins 3, 2 and 0 go to the analog cells in both amplifier modes
`define AOP_AMP_PINS 4'hD

// ahb htrans bit that marks an active transfer
`define AOP_HTRANS_ACT 1

`endif

// File: verilog/aop_sync2.v
// two flip-flop synchroniser for a bundle of independent levels
// assumes: each bit is a level, no word coherence across bits needed
`timescale 1ns/1ps
`default_nettype none
module aop_sync2
#(
  parameter W = 1
)
(
  input wire CLK,
  input wire NRST,
  input wire [W-1:0] D,
  output wire [W-1:0] Q
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // first stage feeds only the second stage
  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end
    else
    begin
      meta_reg <= D;
      sync_reg <= meta_reg;
    end
  end

  assign Q = sync_reg;

endmodule
`default_nettype wire

// File: verilog/aop_pin_cell.v
// one pad control cell: drive enable, output level, weak pull-down
// assumes: inputs are registered option/control bits of the port, except analog, which is decoded from them
`timescale 1ns/1ps
`default_nettype none
module aop_pin_cell
(
  input wire dir_bit,
  input wire bidir,
  input wire analog,
  input wire pd_opt,
  input wire latch,
  output wire out_mode,
  output wire oe,
  output wire out,
  output wire pd_en
);

  // direction only counts on a bidirectional port
  assign out_mode = dir_bit & bidir;
  // analog pins must never be fought by the digital driver
  assign oe = out_mode & ~analog;
  assign out = latch & oe;
  // pull-down only while the pin listens
  assign pd_en = pd_opt & ~out_mode & ~analog;

endmodule
`default_nettype wire

// File: verilog/aop_port.v
// analog option port: 4-bit i/o port with amplifier/comparator modes
// assumes: ahb-lite single slave, word transfers, pads and analog
// cells outside; pin and comparator levels are asynchronous to CLK
//
// Behaviour
// - direction bit 1 output, 0 input
// - direction used only on bidirectional port
// - pull-down per option, only in input
// - modes chosen only by enable options
// - amplifier-only option gives single amplifier mode
// - each comparator enabled by own option
// - bit-1 read-zero option forces bit 1 zero while comparator 1 is on
// - bit-3 read-zero option forces bit 3 zero while comparator 2 is on
// - first comparator result read on bit 0
// - second comparator result read on bit 2
// - no enables means pure digital port
// - comparator-plus-amplifier reads bits 3,2 zero
// - comparator-plus-amplifier bit 1 reads pad unless bit-1 read-zero is set
// - data writes stored and driven on outputs
// - output pins read back latch value
`timescale 1ns/1ps
`default_nettype none
`include "aop_defs.vh"
module aop_port
(
  input wire CLK,
  input wire NRST,
  // ahb-lite slave
  input wire HSEL,
  input wire [`AOP_AW-1:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [`AOP_DW-1:0] HWDATA,
  input wire HREADY,
  output wire HREADYOUT,
  output wire HRESP,
  output wire [`AOP_DW-1:0] HRDATA,
  // pads
  input wire [`AOP_NPIN-1:0] PIN_IN,
  output wire [`AOP_NPIN-1:0] PIN_OUT,
  output wire [`AOP_NPIN-1:0] PIN_OE,
  output wire [`AOP_NPIN-1:0] PIN_PD_EN,
  output wire [`AOP_NPIN-1:0] PIN_ANALOG,
  // analog cells
  input wire CMP1_RESULT,
  input wire CMP2_RESULT,
  output wire AMP_ENABLE,
  output wire CMP1_ENABLE,
  output wire CMP2_ENABLE
);

  localparam NP = `AOP_NPIN;
  localparam OW = `AOP_OPT_W;
  localparam MW = `AOP_MODE_W;
  localparam SW = `AOP_NPIN + 2;

  // bus front end state
  reg wr_pend_reg;
  reg [5:0] wr_idx_reg;
  reg [`AOP_DW-1:0] rdata_reg;
  reg [`AOP_DW-1:0] rdata_next;

  // software visible state
  reg [NP-1:0] dir_reg;
  reg [NP-1:0] dir_next;
  reg [NP-1:0] data_reg;
  reg [NP-1:0] data_next;
  reg [OW-1:0] opt_reg;
  reg [OW-1:0] opt_next;

  // decoded address phase
  wire addr_take;
  wire addr_ok;
  wire [5:0] addr_idx;

  // option fields of the next state, used for read forwarding
  wire amp_n;
  wire cmp1_n;
  wire cmp2_n;
  wire rz1_n;
  wire rz3_n;
  wire bidir_n;
  wire [NP-1:0] pd_n;

  // option fields of the current state, used for pad control
  wire amp_q;
  wire cmp1_q;
  wire cmp2_q;
  wire bidir_q;
  wire [NP-1:0] pd_q;

  // synchronised pad and comparator levels
  wire [SW-1:0] async_in;
  wire [SW-1:0] sync_in;
  wire [NP-1:0] pad_s;
  wire cmp1_s;
  wire cmp2_s;

  // mode and pin assignment
  reg [MW-1:0] mode_next;
  reg [MW-1:0] mode_q;
  reg [NP-1:0] analog_next;
  reg [NP-1:0] analog_q;
  reg [NP-1:0] port_rd;
  wire [NP-1:0] out_mode_q;
  wire [NP-1:0] out_mode_n;

  // zero wait states; every answer is okay
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_reg;

  // an address phase counts only when the bus is ready
  // the index is kept every cycle; only wr_pend_reg qualifies it
  assign addr_take = HSEL & HTRANS[`AOP_HTRANS_ACT] & HREADY;
  assign addr_idx = HADDR[7:2];
  // only aligned word addresses in the low window decode
  assign addr_ok = (HADDR[`AOP_AW-1:8] == 24'h000000)
    & (HADDR[1:0] == 2'h0);

  // register writes land in the data phase, from hwdata
  // the mode register is read-only, so writes to it are dropped
  always @*
  begin
    dir_next = dir_reg;
    data_next = data_reg;
    opt_next = opt_reg;
    if (wr_pend_reg)
    begin
      case (wr_idx_reg)
        `AOP_IDX_DIR: dir_next = HWDATA[NP-1:0];
        `AOP_IDX_DATA: data_next = HWDATA[NP-1:0];
        `AOP_IDX_OPT: opt_next = HWDATA[OW-1:0];
        default: dir_next = dir_reg;
      endcase
    end
  end

  // state registers and the pending write of the last address phase
  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      dir_reg <= `AOP_DIR_RST;
      data_reg <= `AOP_DATA_RST;
      opt_reg <= `AOP_OPT_RST;
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 6'h00;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      dir_reg <= dir_next;
      data_reg <= data_next;
      opt_reg <= opt_next;
      wr_pend_reg <= addr_take & HWRITE & addr_ok;
      wr_idx_reg <= addr_idx;
      rdata_reg <= rdata_next;
    end
  end

  // option field taps
  assign amp_n = opt_next[`AOP_OPT_AMP];
  assign cmp1_n = opt_next[`AOP_OPT_CMP1];
  assign cmp2_n = opt_next[`AOP_OPT_CMP2];
  assign rz1_n = opt_next[`AOP_OPT_RZ1];
  assign rz3_n = opt_next[`AOP_OPT_RZ3];
  assign bidir_n = opt_next[`AOP_OPT_BIDIR];
  assign pd_n = opt_next[`AOP_OPT_PD_HI:`AOP_OPT_PD_LO];
  assign amp_q = opt_reg[`AOP_OPT_AMP];
  assign cmp1_q = opt_reg[`AOP_OPT_CMP1];
  assign cmp2_q = opt_reg[`AOP_OPT_CMP2];
  assign bidir_q = opt_reg[`AOP_OPT_BIDIR];
  assign pd_q = opt_reg[`AOP_OPT_PD_HI:`AOP_OPT_PD_LO];

  // analog cells follow their own enables only
  assign AMP_ENABLE = amp_q;
  assign CMP1_ENABLE = cmp1_q;
  assign CMP2_ENABLE = cmp2_q;

  // pads and comparators are asynchronous
  // a level change reaches a read two edges later
  assign async_in = {CMP2_RESULT, CMP1_RESULT, PIN_IN};

  aop_sync2
  #(
    .W(SW)
  )
  u_sync
  (
    .CLK(CLK),
    .NRST(NRST),
    .D(async_in),
    .Q(sync_in)
  );

  assign pad_s = sync_in[NP-1:0];
  assign cmp1_s = sync_in[NP];
  assign cmp2_s = sync_in[NP+1];

  // mode decode from next options, so a read right after an option
  // write already sees the new mode
  always @*
  begin
    mode_next = `AOP_MODE_PURE;
    analog_next = 4'h0;
    if (amp_n & cmp1_n & ~cmp2_n)
    begin
      // amplifier on pins 3,2,0, comparator result on bit 0
      mode_next = `AOP_MODE_CMPAMP;
      analog_next = `AOP_AMP_PINS;
    end
    else if (amp_n & ~cmp1_n & ~cmp2_n)
    begin
      mode_next = `AOP_MODE_AMP;
      analog_next = `AOP_AMP_PINS;
    end
    else if (cmp1_n | cmp2_n)
    begin
      // comparator inputs take pins 0 and 2 as enabled
      // all three enables together is not legal and lands here
      mode_next = `AOP_MODE_CMP;
      analog_next = {1'b0, cmp2_n, 1'b0, cmp1_n};
    end
  end

  // same decode on the current options, for the pads
  always @*
  begin
    mode_q = `AOP_MODE_PURE;
    analog_q = 4'h0;
    if (amp_q & cmp1_q & ~cmp2_q)
    begin
      mode_q = `AOP_MODE_CMPAMP;
      analog_q = `AOP_AMP_PINS;
    end
    else if (amp_q & ~cmp1_q & ~cmp2_q)
    begin
      mode_q = `AOP_MODE_AMP;
      analog_q = `AOP_AMP_PINS;
    end
    else if (cmp1_q | cmp2_q)
    begin
      mode_q = `AOP_MODE_CMP;
      analog_q = {1'b0, cmp2_q, 1'b0, cmp1_q};
    end
  end

  assign PIN_ANALOG = analog_q;

  // one pad cell per pin
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi = gi + 1)
    begin : g_pin
      aop_pin_cell u_cell
      (
        .dir_bit(dir_reg[gi]),
        .bidir(bidir_q),
        .analog(analog_q[gi]),
        .pd_opt(pd_q[gi]),
        .latch(data_reg[gi]),
        .out_mode(out_mode_q[gi]),
        .oe(PIN_OE[gi]),
        .out(PIN_OUT[gi]),
        .pd_en(PIN_PD_EN[gi])
      );
    end
  endgenerate

  // read-side direction, from next values for forwarding
  assign out_mode_n = dir_next & {NP{bidir_n}};

  // data read value; later assignments take priority
  always @*
  begin
    // outputs read the latch, inputs the synced pad
    // single amplifier mode keeps this plain port read
    port_rd = (data_next & out_mode_n) | (pad_s & ~out_mode_n);
    if (cmp1_n)
    begin
      port_rd[`AOP_BIT_CMP1] = cmp1_s;
      if (rz1_n)
      begin
        port_rd[`AOP_BIT_Z1] = 1'b0;
      end
      else
      begin
        port_rd[`AOP_BIT_Z1] = pad_s[`AOP_BIT_Z1];
      end
    end
    if (cmp2_n)
    begin
      port_rd[`AOP_BIT_CMP2] = cmp2_s;
      if (rz3_n)
      begin
        port_rd[`AOP_BIT_Z3] = 1'b0;
      end
      else
      begin
        port_rd[`AOP_BIT_Z3] = pad_s[`AOP_BIT_Z3];
      end
    end
    if (mode_next == `AOP_MODE_CMPAMP)
    begin
      // amplifier owns pins 3,2 here
      port_rd[`AOP_BIT_CMP2] = 1'b0;
      port_rd[`AOP_BIT_Z3] = 1'b0;
    end
  end

  // read data is built in the address phase and held in a flop,
  // so hrdata stands steady through the data phase
  always @*
  begin
    rdata_next = rdata_reg;
    if (addr_take & ~HWRITE)
    begin
      // unmapped or misaligned reads answer zero
      rdata_next = 32'h00000000;
      if (addr_ok)
      begin
        case (addr_idx)
          `AOP_IDX_DIR: rdata_next[NP-1:0] = dir_next;
          `AOP_IDX_DATA: rdata_next[NP-1:0] = port_rd;
          `AOP_IDX_OPT: rdata_next[OW-1:0] = opt_next;
          `AOP_IDX_MODE: rdata_next[2*NP-1:0] = {analog_next, mode_next};
          default: rdata_next = 32'h00000000;
        endcase
      end
    end
  end

  // hsize is not checked: every access is treated as a full word
  // and narrow writes take the whole of hwdata

endmodule
`default_nettype wire

// File: verification/aop_pads.sv
// pad and comparator model facing the analog option port
// assumes: bench sets external levels; one clock, no real analog
`timescale 1ns/1ps
`default_nettype none
module aop_pads
(
  input wire logic CLK,
  input wire logic [3:0] PIN_OUT,
  input wire logic [3:0] PIN_OE,
  input wire logic [3:0] PIN_PD_EN,
  input wire logic [3:0] EXT_VAL,
  input wire logic [3:0] EXT_EN,
  input wire logic CMP1_ENABLE,
  input wire logic CMP2_ENABLE,
  input wire logic [1:0] CMP_VAL,
  output logic [3:0] PIN_IN,
  output logic CMP1_RESULT,
  output logic CMP2_RESULT
);
  logic tog = 1'b0;
  // a floating node wanders, so undriven lines toggle
  always @(posedge CLK)
    tog <= ~tog;
  // port driver wins, then bench, then pull-down, else floating
  always_comb
    for (int i = 0; i < 4; i++)
      PIN_IN[i] = PIN_OE[i] ? PIN_OUT[i] : EXT_EN[i] ? EXT_VAL[i] :
        PIN_PD_EN[i] ? 1'b0 : tog;
  // a disabled comparator gives nothing useful
  assign CMP1_RESULT = CMP1_ENABLE ? CMP_VAL[0] : tog;
  assign CMP2_RESULT = CMP2_ENABLE ? CMP_VAL[1] : tog;
endmodule
`default_nettype wire

// File: verification/aop_port_assertions.sv
// concurrent checks on the analog option port's bus and pad pins
// assumes: bound to aop_port; one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module aop_port_chk
(
  input wire CLK,
  input wire NRST,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire HREADY,
  input wire HREADYOUT,
  input wire HRESP,
  input wire [31:0] HRDATA,
  input wire [3:0] PIN_OUT,
  input wire [3:0] PIN_OE,
  input wire [3:0] PIN_PD_EN,
  input wire [3:0] PIN_ANALOG,
  input wire CMP1_RESULT,
  input wire CMP2_RESULT,
  input wire AMP_ENABLE,
  input wire CMP1_ENABLE,
  input wire CMP2_ENABLE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // decoded read address phases
  wire rd_take = HSEL && HTRANS[1] && HREADY && !HWRITE;
  wire rd_dat = rd_take && HADDR == 32'h00000010;
  wire [2:0] en = {CMP2_ENABLE, CMP1_ENABLE, AMP_ENABLE};

  bus_okay_a: assert property (HREADYOUT && !HRESP)
    else $error("bus answer not zero-wait okay");
  hold_rdata_a: assert property (!rd_take |=> $stable(HRDATA))
    else $error("read data moved without a read");
  out_gate_a: assert property ((PIN_OUT & ~PIN_OE) == 4'h0)
    else $error("pin level high on undriven pin");
  pd_output_a: assert property ((PIN_PD_EN & PIN_OE) == 4'h0)
    else $error("pull-down on a driven pin");
  analog_free_a: assert property
    ((PIN_ANALOG & (PIN_OE | PIN_PD_EN)) == 4'h0)
    else $error("analog pin driven or pulled");
  pure_port_a: assert property (en == 3'h0 |-> PIN_ANALOG == 4'h0)
    else $error("analog pin in pure port");
  cmp_pin_a: assert property (CMP1_ENABLE |-> PIN_ANALOG[0])
    else $error("comparator pin not analog");
  cmp1_read_a: assert property
    (rd_dat ##1 (CMP1_ENABLE && $stable(en))
    |-> HRDATA[0] == $past(CMP1_RESULT, 3))
    else $error("bit 0 not synced comparator");
  cmp2_read_a: assert property
    (rd_dat ##1 (CMP2_ENABLE && $stable(en))
    |-> HRDATA[2] == $past(CMP2_RESULT, 3))
    else $error("bit 2 not synced comparator");
  cmpamp_zero_a: assert property
    (rd_dat ##1 (en == 3'h3 && $stable(en))
    |-> HRDATA[3:2] == 2'h0)
    else $error("upper bits not zero");
  cover property (rd_dat ##1 en == 3'h3);
  cover property (PIN_OE != 4'h0);
  cover property (PIN_PD_EN != 4'h0);
endmodule
bind aop_port aop_port_chk u_chk (.CLK, .NRST, .HSEL, .HADDR, .HTRANS,
  .HWRITE, .HREADY, .HREADYOUT, .HRESP, .HRDATA, .PIN_OUT, .PIN_OE,
  .PIN_PD_EN, .PIN_ANALOG, .CMP1_RESULT, .CMP2_RESULT, .AMP_ENABLE,
  .CMP1_ENABLE, .CMP2_ENABLE);
`default_nettype wire

// File: verification/tb_aop_port.sv
// self-checking bench for the analog option port over ahb-lite
// assumes: aop_port, the aop_pads model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_aop_port;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic [3:0] ext_val = 4'hA;
  logic [3:0] ext_en = 4'hF;
  logic [1:0] cmp_val = 2'h3;
  logic [31:0] rd;
  logic [31:0] en;
  wire HREADYOUT, HRESP, CMP1_RESULT, CMP2_RESULT;
  wire AMP_ENABLE, CMP1_ENABLE, CMP2_ENABLE;
  wire [31:0] HRDATA;
  wire [3:0] PIN_IN, PIN_OUT, PIN_OE, PIN_PD_EN, PIN_ANALOG;
  int fail_count = 0;
  int cmp_count = 0;
  // option settings, expected data read and mode code
  logic [9:0] opt_t [11] = '{10'h000, 10'h018, 10'h002, 10'h00A, 10'h004,
    10'h014, 10'h006, 10'h01E, 10'h001, 10'h003, 10'h00B};
  logic [3:0] dat_t [11] = '{4'hA, 4'hA, 4'hB, 4'h9, 4'hE, 4'h6, 4'hF,
    4'h5, 4'hA, 4'h3, 4'h1};
  logic [7:0] mod_t [11] = '{8'h01, 8'h01, 8'h14, 8'h14, 8'h44, 8'h44, 8'h54,
    8'h54, 8'hD2, 8'hD8, 8'hD8};

  always #2.5 CLK = ~CLK;

  aop_port dut (.CLK, .NRST, .HSEL, .HADDR, .HTRANS, .HWRITE,
    .HSIZE(3'h2), .HWDATA, .HREADY(HREADYOUT), .HREADYOUT, .HRESP,
    .HRDATA, .PIN_IN, .PIN_OUT, .PIN_OE, .PIN_PD_EN, .PIN_ANALOG,
    .CMP1_RESULT, .CMP2_RESULT, .AMP_ENABLE, .CMP1_ENABLE, .CMP2_ENABLE);
  aop_pads pads (.CLK, .PIN_OUT, .PIN_OE, .PIN_PD_EN, .EXT_VAL(ext_val),
    .EXT_EN(ext_en), .CMP1_ENABLE, .CMP2_ENABLE, .CMP_VAL(cmp_val), .PIN_IN,
    .CMP1_RESULT, .CMP2_RESULT);

  // one single word transfer; waits on ready, no fixed latency assumed
  task automatic xfer(input logic wr, input logic [31:0] a,
    input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR <= a;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    rd = HRDATA;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard, far beyond the some 170 cycles the tests take
  initial
  begin
    #20000;
    fail_count++;
    final_report;
  end

  // main sequence
  initial
  begin
    repeat (20) @(posedge CLK);
    NRST <= 1'b1;
    @(posedge CLK);
    rchk(32'h04, 32'h0);
    rchk(32'h20, 32'h0);
    rchk(32'h10, 32'hA);
    xfer(1'b1, 32'h0C, 32'hF);
    rchk(32'h0C, 32'h0);
    xfer(1'b1, 32'h20, 32'h3E0);
    xfer(1'b1, 32'h04, 32'hA);
    xfer(1'b1, 32'h10, 32'hF);
    rchk(32'h10, 32'hA);
    chk({28'h0, PIN_OE}, 32'hA);
    chk({28'h0, PIN_OUT}, 32'hA);
    chk({28'h0, PIN_PD_EN}, 32'h5);
    ext_val <= 4'h5;
    rchk(32'h10, 32'hA);
    rchk(32'h10, 32'hF);
    ext_en <= 4'h0;
    xfer(1'b1, 32'h20, 32'h3C0);
    repeat (2) @(posedge CLK);
    rchk(32'h10, 32'h0);
    chk({28'h0, PIN_OE}, 32'h0);
    chk({28'h0, PIN_PD_EN}, 32'hF);
    xfer(1'b1, 32'h04, 32'h0);
    ext_val <= 4'hA;
    ext_en <= 4'hF;
    for (int i = 0; i < 11; i++)
    begin
      xfer(1'b1, 32'h20, {22'h0, opt_t[i]});
      repeat (3) @(posedge CLK);
      en = {29'h0, CMP2_ENABLE, CMP1_ENABLE, AMP_ENABLE};
      chk(en, {29'h0, opt_t[i][2:0]});
      rchk(32'h10, {28'h0, dat_t[i]});
      xfer(1'b0, 32'h24, 32'h0);
      chk({24'h0, rd[7:0]}, {24'h0, mod_t[i]});
      chk({28'h0, PIN_ANALOG}, {28'h0, mod_t[i][7:4]});
    end
    // comparator levels low, then a rise that must take two edges
    cmp_val <= 2'h0;
    xfer(1'b1, 32'h20, 32'h006);
    repeat (3) @(posedge CLK);
    rchk(32'h10, 32'hA);
    cmp_val <= 2'h1;
    rchk(32'h10, 32'hA);
    rchk(32'h10, 32'hB);
    // reset in mid-run clears the options back to a pure port
    NRST <= 1'b0;
    repeat (2) @(posedge CLK);
    NRST <= 1'b1;
    @(posedge CLK);
    rchk(32'h20, 32'h0);
    chk({28'h0, PIN_ANALOG}, 32'h0);
    final_report;
  end
endmodule
`default_nettype wire
